// File: rtl/daoc_pkg.sv
// constants, types and helpers shared by the dual converter output control
//
// What this block does
// - low two levels offset binary, high two twos
// - stabiliser on only for middle two levels
// - one format input serves both channels
// - overrange flag high when input beyond full scale
// - output enable high floats data and flag
// - each output bus has its own output enable
// - power-down low means normal conversion
// - power-down and enable high means sleep
// - after sleep data invalid for one millisecond
// - power-down high, enable low means nap
// - sleep and nap float all channel outputs
// - channel power states fully independent
// - swap select high keeps buses straight
// - swap select low exchanges the two buses
// - fourteen bit codes, saturate on overrange
// - stabiliser needs hundred samples after clock gap
package daoc_pkg;

  // ***************************************************************
  // widths, levels and codes
  // ***************************************************************
  localparam int CODE_W = 14;
  localparam int CNT_W = 16;
  localparam logic [1:0] LVL_GND = 2'h0;
  localparam logic [1:0] LVL_THIRD = 2'h1;
  localparam logic [1:0] LVL_TWO_THIRDS = 2'h2;
  localparam logic [1:0] LVL_VDD = 2'h3;
  localparam logic [CODE_W-1:0] CODE_MAX = 14'h3fff;
  localparam logic [CODE_W-1:0] CODE_MIN = 14'h0000;

  // ***************************************************************
  // timing
  // ***************************************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int SLEEP_RECOVERY_US = 1000;
  localparam int SLEEP_RECOVERY_CYC =
    (SLEEP_RECOVERY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CLK_ABSENT_US = 100;
  localparam int CLK_ABSENT_CYC = CLK_ABSENT_US * 1000 / CLK_PERIOD_NS;
  localparam logic [CNT_W-1:0] NAP_RECOVERY_SAMPLES = 16'h0064;
  localparam logic [CNT_W-1:0] PLL_LOCK_SAMPLES = 16'h0064;

  // ***************************************************************
  // register map
  // ***************************************************************
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADR_IRQ_MASK = 8'h0c;
  localparam int CTRL_OVERRIDE_BIT = 0;
  localparam int CTRL_LVL_LSB = 1;
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam int IRQ_W = 4;
  localparam int IRQ_OVR_A = 0;
  localparam int IRQ_OVR_B = 1;
  localparam int IRQ_RDY_A = 2;
  localparam int IRQ_RDY_B = 3;
  localparam logic [IRQ_W-1:0] IRQ_RST = 4'h0;
  localparam int STAT_STATE_A_LSB = 0;
  localparam int STAT_STATE_B_LSB = 4;
  localparam int STAT_VALID_A = 8;
  localparam int STAT_VALID_B = 9;
  localparam int STAT_TWOS = 10;
  localparam int STAT_DCS = 11;
  localparam int STAT_SWAP = 12;

  // ***************************************************************
  // types
  // ***************************************************************
  typedef struct packed {
    logic [CODE_W-1:0] code;
    logic over_pos;
    logic over_neg;
  } daoc_conv_t;

  typedef struct packed {
    logic [CODE_W-1:0] code;
    logic ovr;
    logic active;
    logic valid;
  } daoc_chan_t;

  typedef enum logic [3:0] {
    ST_RUN = 4'b0001,
    ST_NAP = 4'b0010,
    ST_SLEEP = 4'b0100,
    ST_WAKE = 4'b1000
  } daoc_pwr_t;

  // ***************************************************************
  // decoding helpers
  // ***************************************************************
  function automatic logic fmt_twos(input logic [1:0] lvl);
    fmt_twos = (lvl == LVL_TWO_THIRDS) || (lvl == LVL_VDD);
  endfunction

  function automatic logic dcs_on(input logic [1:0] lvl);
    dcs_on = (lvl == LVL_THIRD) || (lvl == LVL_TWO_THIRDS);
  endfunction

  function automatic logic [CODE_W-1:0] code_out(input daoc_conv_t c,
                                                 input logic twos);
    logic [CODE_W-1:0] ob;
    ob = c.over_pos ? CODE_MAX : (c.over_neg ? CODE_MIN : c.code);
    code_out = twos ? {~ob[CODE_W-1], ob[CODE_W-2:0]} : ob;
  endfunction

endpackage

// File: rtl/daoc_chan.sv
// one conversion channel: power state, recovery, lock and output word
`timescale 1ns/10ps
`default_nettype none
module daoc_chan #(
  parameter int unsigned SLEEP_CYC = daoc_pkg::SLEEP_RECOVERY_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_sample,
  input wire daoc_pkg::daoc_conv_t i_conv,
  input wire logic i_pd,
  input wire logic i_oe_n,
  input wire logic i_twos,
  input wire logic i_dcs,
  output var daoc_pkg::daoc_chan_t o_chan,
  output var daoc_pkg::daoc_pwr_t o_state,
  output logic o_ready
);

  // ***************************************************************
  // state
  // ***************************************************************
  daoc_pkg::daoc_pwr_t state_reg, state_next;
  logic [daoc_pkg::CNT_W-1:0] wake_reg, wake_next;
  logic ref_down_reg, ref_down_next;
  logic [daoc_pkg::CNT_W-1:0] gap_reg, gap_next;
  logic [daoc_pkg::CNT_W-1:0] lock_reg, lock_next;
  daoc_pkg::daoc_chan_t chan_reg, chan_next;
  logic ready_reg, ready_next;

  // power state machine, recovery counting and output word
  always_comb
  begin
    state_next = state_reg;
    wake_next = wake_reg;
    ref_down_next = ref_down_reg;
    ready_next = 1'b0;
    case (state_reg)
      daoc_pkg::ST_RUN:
      begin
        ref_down_next = 1'b0;
        if (i_pd)
          state_next = i_oe_n ? daoc_pkg::ST_SLEEP : daoc_pkg::ST_NAP;
      end
      daoc_pkg::ST_NAP:
      begin
        if (!i_pd)
        begin
          state_next = daoc_pkg::ST_WAKE;
          wake_next = ref_down_reg ? daoc_pkg::CNT_W'(SLEEP_CYC)
                                   : daoc_pkg::NAP_RECOVERY_SAMPLES;
        end
        else if (i_oe_n)
          state_next = daoc_pkg::ST_SLEEP;
      end
      daoc_pkg::ST_SLEEP:
      begin
        ref_down_next = 1'b1;
        if (!i_pd)
        begin
          state_next = daoc_pkg::ST_WAKE;
          wake_next = daoc_pkg::CNT_W'(SLEEP_CYC);
        end
        else if (!i_oe_n)
          state_next = daoc_pkg::ST_NAP;
      end
      daoc_pkg::ST_WAKE:
      begin
        if (i_pd)
          state_next = i_oe_n ? daoc_pkg::ST_SLEEP : daoc_pkg::ST_NAP;
        else if (ref_down_reg || i_sample)
        begin
          if (wake_reg <= 16'h0001)
          begin
            state_next = daoc_pkg::ST_RUN;
            ready_next = 1'b1;
          end
          else
            wake_next = wake_reg - 16'h0001;
        end
      end
      default:
        state_next = daoc_pkg::ST_SLEEP;
    endcase
    // sample gap watch and stabiliser lock
    if (i_sample)
      gap_next = '0;
    else if (gap_reg == daoc_pkg::CNT_W'(daoc_pkg::CLK_ABSENT_CYC))
      gap_next = gap_reg;
    else
      gap_next = gap_reg + 16'h0001;
    if (!i_dcs)
      lock_next = '0;
    else if (gap_reg == daoc_pkg::CNT_W'(daoc_pkg::CLK_ABSENT_CYC))
      lock_next = daoc_pkg::PLL_LOCK_SAMPLES;
    else if (i_sample && lock_reg != '0)
      lock_next = lock_reg - 16'h0001;
    else
      lock_next = lock_reg;
    chan_next = chan_reg;
    if (i_sample && state_reg == daoc_pkg::ST_RUN)
    begin
      chan_next.code = daoc_pkg::code_out(i_conv, i_twos);
      chan_next.ovr = i_conv.over_pos | i_conv.over_neg;
    end
    chan_next.active = (state_next == daoc_pkg::ST_RUN) ||
                       (state_next == daoc_pkg::ST_WAKE);
    chan_next.valid = (state_next == daoc_pkg::ST_RUN) &&
                      (lock_next == '0);
  end

  // registers of the channel
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      state_reg <= daoc_pkg::ST_SLEEP;
      wake_reg <= '0;
      ref_down_reg <= 1'b1;
      gap_reg <= daoc_pkg::CNT_W'(daoc_pkg::CLK_ABSENT_CYC);
      lock_reg <= '0;
      chan_reg <= '0;
      ready_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      wake_reg <= wake_next;
      ref_down_reg <= ref_down_next;
      gap_reg <= gap_next;
      lock_reg <= lock_next;
      chan_reg <= chan_next;
      ready_reg <= ready_next;
    end
  end

  assign o_chan = chan_reg;
  assign o_state = state_reg;
  assign o_ready = ready_reg;

  // ***************************************************************
  // checks
  // ***************************************************************
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  a_sleep_entry: assert property (
    state_reg == daoc_pkg::ST_RUN && i_pd && i_oe_n
    |=> state_reg == daoc_pkg::ST_SLEEP)
    else $error("sleep not entered");
  a_nap_entry: assert property (
    state_reg == daoc_pkg::ST_RUN && i_pd && !i_oe_n
    |=> state_reg == daoc_pkg::ST_NAP)
    else $error("nap not entered");
  a_power_down_float: assert property (
    (state_reg == daoc_pkg::ST_NAP || state_reg == daoc_pkg::ST_SLEEP)
    |-> !chan_reg.active && !chan_reg.valid)
    else $error("outputs active while powered down");
  a_overrange_flag: assert property (
    i_sample && state_reg == daoc_pkg::ST_RUN
    |=> chan_reg.ovr == $past(i_conv.over_pos | i_conv.over_neg))
    else $error("overrange flag wrong");
  a_twos_top_bit: assert property (
    i_sample && state_reg == daoc_pkg::ST_RUN && i_twos &&
    !i_conv.over_pos && !i_conv.over_neg
    |=> chan_reg.code == {~$past(i_conv.code[13]), $past(i_conv.code[12:0])})
    else $error("twos complement code wrong");
  a_lock_blocks_valid: assert property (
    lock_reg != '0 |-> !chan_reg.valid)
    else $error("valid while stabiliser unlocked");
  c_sleep_wake: cover property (
    state_reg == daoc_pkg::ST_WAKE && ref_down_reg ##1
    state_reg == daoc_pkg::ST_RUN);
  c_nap_wake: cover property (
    state_reg == daoc_pkg::ST_WAKE && !ref_down_reg ##1
    state_reg == daoc_pkg::ST_RUN);

endmodule
`default_nettype wire

// File: rtl/daoc_top.sv
// top of the dual converter output control with its register slave
`timescale 1ns/10ps
`default_nettype none
module daoc_top #(
  parameter int unsigned SLEEP_CYC = daoc_pkg::SLEEP_RECOVERY_CYC
) (
  input wire logic I_CLOCK,
  input wire logic I_RST_B,
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [7:0] I_WB_ADR,
  input wire logic [3:0] I_WB_SEL,
  input wire logic [31:0] I_WB_DAT,
  output logic [31:0] O_WB_DAT,
  output logic O_WB_ACK,
  output logic O_IRQ,
  input wire logic [1:0] I_MODE_LEVEL,
  input wire logic I_POWER_DOWN_REQUEST_CHAN_A,
  input wire logic I_POWER_DOWN_REQUEST_CHAN_B,
  input wire logic I_OUTPUT_ENABLE_N_CHAN_A,
  input wire logic I_OUTPUT_ENABLE_N_CHAN_B,
  input wire logic I_BUS_SWAP_SELECT,
  input wire logic I_SAMPLE_CLOCK_CHAN_A,
  input wire logic I_SAMPLE_CLOCK_CHAN_B,
  input wire daoc_pkg::daoc_conv_t I_CONV_A,
  input wire daoc_pkg::daoc_conv_t I_CONV_B,
  output logic [13:0] O_OUTPUT_BUS_A,
  output logic O_OUTPUT_BUS_A_OE,
  output logic [13:0] O_OUTPUT_BUS_B,
  output logic O_OUTPUT_BUS_B_OE,
  output logic O_OVERRANGE_FLAG_BUS_A,
  output logic O_OVERRANGE_FLAG_BUS_A_OE,
  output logic O_OVERRANGE_FLAG_BUS_B,
  output logic O_OVERRANGE_FLAG_BUS_B_OE,
  output logic O_DATA_VALID_BUS_A,
  output logic O_DATA_VALID_BUS_B,
  output logic O_TWOS_FORMAT,
  output logic O_STABILISER_ON,
  output logic O_REF_POWER_CHAN_A,
  output logic O_REF_POWER_CHAN_B
);

  // ***************************************************************
  // pin synchronisers
  // ***************************************************************
  localparam int SYNC_W = 9;
  logic [SYNC_W-1:0] pins;
  logic [SYNC_W-1:0] sync1_reg, sync2_reg;
  logic [1:0] smp_prev_reg;
  logic [1:0] mode_pin;
  logic pd_a, pd_b, oen_a, oen_b, swap, smp_a, smp_b;
  logic [1:0] smp_pulse;

  // gather the pins into one vector
  assign pins = {I_MODE_LEVEL, I_POWER_DOWN_REQUEST_CHAN_A,
                 I_POWER_DOWN_REQUEST_CHAN_B, I_OUTPUT_ENABLE_N_CHAN_A,
                 I_OUTPUT_ENABLE_N_CHAN_B, I_BUS_SWAP_SELECT,
                 I_SAMPLE_CLOCK_CHAN_A, I_SAMPLE_CLOCK_CHAN_B};

  // two flops per pin, then a delayed copy for edge finding
  always_ff @(posedge I_CLOCK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      smp_prev_reg <= '0;
    end
    else
    begin
      sync1_reg <= pins;
      sync2_reg <= sync1_reg;
      smp_prev_reg <= sync2_reg[1:0];
    end
  end

  // split the synchronised vector
  assign {mode_pin, pd_a, pd_b, oen_a, oen_b, swap, smp_a, smp_b} = sync2_reg;
  assign smp_pulse = {smp_a, smp_b} & ~smp_prev_reg; // rising sample edges

  // ***************************************************************
  // register slave
  // ***************************************************************
  logic [2:0] ctrl_reg, ctrl_next;
  logic [daoc_pkg::IRQ_W-1:0] stat_reg, stat_next;
  logic [daoc_pkg::IRQ_W-1:0] mask_reg, mask_next;
  logic [daoc_pkg::IRQ_W-1:0] events;
  logic [1:0] ovr_prev_reg, ovr_prev_next;
  logic ack_reg, ack_next;
  logic [31:0] rdat_reg, rdat_next;
  logic [31:0] status_word;
  logic access, wr_byte0;
  logic [1:0] lvl_eff;
  daoc_pkg::daoc_chan_t chan_a, chan_b;
  daoc_pkg::daoc_pwr_t state_a, state_b;
  logic ready_a, ready_b;
  logic twos_reg, twos_next, dcs_reg, dcs_next;

  // one access per request, acked one cycle after it is seen
  assign access = I_WB_CYC & I_WB_STB & ~ack_reg;
  assign wr_byte0 = access & I_WB_WE & I_WB_SEL[0];

  // format and stabiliser level, pin or software override
  assign lvl_eff = ctrl_reg[daoc_pkg::CTRL_OVERRIDE_BIT] ?
                   ctrl_reg[daoc_pkg::CTRL_LVL_LSB +: 2] : mode_pin;
  assign events = {ready_b, ready_a,
                   chan_b.ovr & ~ovr_prev_reg[1],
                   chan_a.ovr & ~ovr_prev_reg[0]};

  // readable state of both channels
  always_comb
  begin
    status_word = '0;
    status_word[daoc_pkg::STAT_STATE_A_LSB +: 4] = state_a;
    status_word[daoc_pkg::STAT_STATE_B_LSB +: 4] = state_b;
    status_word[daoc_pkg::STAT_VALID_A] = chan_a.valid;
    status_word[daoc_pkg::STAT_VALID_B] = chan_b.valid;
    status_word[daoc_pkg::STAT_TWOS] = twos_reg;
    status_word[daoc_pkg::STAT_DCS] = dcs_reg;
    status_word[daoc_pkg::STAT_SWAP] = swap;
  end

  // next values of the bus registers, the event flags and the mode
  always_comb
  begin
    ack_next = access;
    rdat_next = rdat_reg;
    ctrl_next = ctrl_reg;
    mask_next = mask_reg;
    stat_next = stat_reg;
    if (access && !I_WB_WE)
    begin
      case (I_WB_ADR)
        daoc_pkg::ADR_CTRL: rdat_next = {29'h0, ctrl_reg};
        daoc_pkg::ADR_STATUS: rdat_next = status_word;
        daoc_pkg::ADR_IRQ_STAT: rdat_next = {28'h0, stat_reg};
        daoc_pkg::ADR_IRQ_MASK: rdat_next = {28'h0, mask_reg};
        default: rdat_next = 32'h0;
      endcase
    end
    if (wr_byte0 && I_WB_ADR == daoc_pkg::ADR_CTRL)
      ctrl_next = I_WB_DAT[2:0];
    if (wr_byte0 && I_WB_ADR == daoc_pkg::ADR_IRQ_MASK)
      mask_next = I_WB_DAT[daoc_pkg::IRQ_W-1:0];
    if (wr_byte0 && I_WB_ADR == daoc_pkg::ADR_IRQ_STAT)
      stat_next = stat_reg & ~I_WB_DAT[daoc_pkg::IRQ_W-1:0];
    stat_next = stat_next | events; // a new event beats the clear
    ovr_prev_next = {chan_b.ovr, chan_a.ovr};
    twos_next = daoc_pkg::fmt_twos(lvl_eff);
    dcs_next = daoc_pkg::dcs_on(lvl_eff);
  end

  // registers of the slave and the mode decode
  always_ff @(posedge I_CLOCK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      ack_reg <= 1'b0;
      rdat_reg <= '0;
      ctrl_reg <= daoc_pkg::CTRL_RST;
      mask_reg <= daoc_pkg::IRQ_RST;
      stat_reg <= daoc_pkg::IRQ_RST;
      ovr_prev_reg <= '0;
      twos_reg <= 1'b0;
      dcs_reg <= 1'b0;
    end
    else
    begin
      ack_reg <= ack_next;
      rdat_reg <= rdat_next;
      ctrl_reg <= ctrl_next;
      mask_reg <= mask_next;
      stat_reg <= stat_next;
      ovr_prev_reg <= ovr_prev_next;
      twos_reg <= twos_next;
      dcs_reg <= dcs_next;
    end
  end

  assign O_WB_ACK = ack_reg;
  assign O_WB_DAT = rdat_reg;
  assign O_IRQ = |(stat_reg & mask_reg);
  assign O_TWOS_FORMAT = twos_reg;
  assign O_STABILISER_ON = dcs_reg;

  // ***************************************************************
  // channels
  // ***************************************************************
  // each channel sees only its own power-down and enable pins
  daoc_chan #(.SLEEP_CYC(SLEEP_CYC)) u_chan_a (
    .i_clk(I_CLOCK),
    .i_rst_b(I_RST_B),
    .i_sample(smp_pulse[1]),
    .i_conv(I_CONV_A),
    .i_pd(pd_a),
    .i_oe_n(oen_a),
    .i_twos(twos_reg),
    .i_dcs(dcs_reg),
    .o_chan(chan_a),
    .o_state(state_a),
    .o_ready(ready_a)
  );

  daoc_chan #(.SLEEP_CYC(SLEEP_CYC)) u_chan_b (
    .i_clk(I_CLOCK),
    .i_rst_b(I_RST_B),
    .i_sample(smp_pulse[0]),
    .i_conv(I_CONV_B),
    .i_pd(pd_b),
    .i_oe_n(oen_b),
    .i_twos(twos_reg),
    .i_dcs(dcs_reg),
    .o_chan(chan_b),
    .o_state(state_b),
    .o_ready(ready_b)
  );

  // ***************************************************************
  // bus routing and drivers
  // ***************************************************************
  daoc_pkg::daoc_chan_t bus_a_reg, bus_a_next, bus_b_reg, bus_b_next;
  logic oe_a_reg, oe_a_next, oe_b_reg, oe_b_next;

  // swap select high keeps channels on their own buses, low swaps them
  always_comb
  begin
    bus_a_next = swap ? chan_a : chan_b;
    bus_b_next = swap ? chan_b : chan_a;
    oe_a_next = ~oen_a & bus_a_next.active;
    oe_b_next = ~oen_b & bus_b_next.active;
  end

  // output flops feeding the pads
  always_ff @(posedge I_CLOCK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      bus_a_reg <= '0;
      bus_b_reg <= '0;
      oe_a_reg <= 1'b0;
      oe_b_reg <= 1'b0;
    end
    else
    begin
      bus_a_reg <= bus_a_next;
      bus_b_reg <= bus_b_next;
      oe_a_reg <= oe_a_next;
      oe_b_reg <= oe_b_next;
    end
  end

  // data and flag share one enable per bus
  assign O_OUTPUT_BUS_A = bus_a_reg.code;
  assign O_OUTPUT_BUS_B = bus_b_reg.code;
  assign O_OVERRANGE_FLAG_BUS_A = bus_a_reg.ovr;
  assign O_OVERRANGE_FLAG_BUS_B = bus_b_reg.ovr;
  assign O_OUTPUT_BUS_A_OE = oe_a_reg;
  assign O_OUTPUT_BUS_B_OE = oe_b_reg;
  assign O_OVERRANGE_FLAG_BUS_A_OE = oe_a_reg;
  assign O_OVERRANGE_FLAG_BUS_B_OE = oe_b_reg;
  assign O_DATA_VALID_BUS_A = bus_a_reg.valid & oe_a_reg;
  assign O_DATA_VALID_BUS_B = bus_b_reg.valid & oe_b_reg;
  assign O_REF_POWER_CHAN_A = (state_a != daoc_pkg::ST_SLEEP);
  assign O_REF_POWER_CHAN_B = (state_b != daoc_pkg::ST_SLEEP);

  // ***************************************************************
  // checks
  // ***************************************************************
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (!I_RST_B);

  a_format_decode: assert property (
    !ctrl_reg[0] ##1 !ctrl_reg[0]
    |-> O_TWOS_FORMAT == $past(mode_pin[1]))
    else $error("format does not follow level");
  a_stabiliser_decode: assert property (
    !ctrl_reg[0] ##1 !ctrl_reg[0]
    |-> O_STABILISER_ON == ($past(mode_pin[1]) ^ $past(mode_pin[0])))
    else $error("stabiliser does not follow level");
  a_swap_straight: assert property (
    swap |=> O_OUTPUT_BUS_A == $past(chan_a.code) &&
             O_OVERRANGE_FLAG_BUS_B == $past(chan_b.ovr))
    else $error("straight routing wrong");
  a_swap_crossed: assert property (
    !swap |=> O_OUTPUT_BUS_B == $past(chan_a.code) &&
              O_OVERRANGE_FLAG_BUS_A == $past(chan_b.ovr))
    else $error("crossed routing wrong");
  a_enable_gates_bus: assert property (
    oen_a |=> !O_OUTPUT_BUS_A_OE && !O_OVERRANGE_FLAG_BUS_A_OE)
    else $error("bus a driven while disabled");
  a_irq_sticky: assert property (
    stat_reg[0] && !(wr_byte0 && I_WB_ADR == daoc_pkg::ADR_IRQ_STAT)
    |=> stat_reg[0])
    else $error("event flag lost");
  a_wb_ack_once: assert property (
    O_WB_ACK |=> !O_WB_ACK)
    else $error("ack held two cycles");
  c_swap_toggle: cover property (swap ##1 !swap);
  c_one_sleeps: cover property (
    state_a == daoc_pkg::ST_RUN && state_b == daoc_pkg::ST_SLEEP);
  c_irq_raised: cover property (!O_IRQ ##1 O_IRQ);

endmodule
`default_nettype wire

// File: sim/daoc_rx.sv
// receiving logic model: sample clock, swap tie and valid word capture
`timescale 1ns/10ps
`default_nettype none
module daoc_rx (
  input wire logic i_clk,
  input wire logic i_mux,
  input wire logic i_swap,
  input wire logic i_valid,
  input wire logic [13:0] i_bus,
  output logic o_sclk,
  output logic o_swap,
  output logic [13:0] o_word
);
  logic [2:0] div_reg = 3'h0;
  // free running sample clock, four clocks high and four low
  always_ff @(posedge i_clk)
  begin
    div_reg <= div_reg + 3'h1;
    if (div_reg == 3'h3 && i_valid)
      o_word <= i_bus;
  end
  assign o_sclk = div_reg[2];
  // multiplexed mode ties swap to the shared sample clock
  assign o_swap = i_mux ? o_sclk : i_swap;
endmodule
`default_nettype wire

// File: sim/dual_adc_output_control_tb_top.sv
// self-checking bench of the dual converter output control
`timescale 1ns/10ps
`default_nettype none
module dual_adc_output_control_tb_top;
  typedef struct packed {
    logic [1:0] lvl;
    logic [13:0] code;
    logic pos;
    logic neg;
    logic [13:0] exp;
    logic of;
  } daoc_row_t;
  logic clk, rst_b, cyc, stb, we, ack, irq, swap, sclk, swap_cmd, bus_swap_select;
  logic [7:0] adr;
  logic [31:0] wdat, rdat, q;
  logic [1:0] lvl;
  logic pd_a, pd_b, oe_a, oe_b, twos, dcs, va, vb, rfa, rfb;
  logic output_enable_n_chan_a, output_enable_n_chan_b, overrange_flag_bus_a, overrange_flag_bus_b, ofoea, ofoeb;
  logic [13:0] bus_a, bus_b, word;
  daoc_pkg::daoc_conv_t conv_a, conv_b;
  int miscompares = 0;
  int check_count = 0;
  daoc_row_t rows [6] = '{
    '{2'h0, 14'h2000, 1'b0, 1'b0, 14'h2000, 1'b0},
    '{2'h1, 14'h0001, 1'b0, 1'b0, 14'h0001, 1'b0},
    '{2'h2, 14'h2000, 1'b0, 1'b0, 14'h0000, 1'b0},
    '{2'h3, 14'h1fff, 1'b0, 1'b0, 14'h3fff, 1'b0},
    '{2'h2, 14'h0005, 1'b1, 1'b0, 14'h1fff, 1'b1},
    '{2'h0, 14'h0005, 1'b0, 1'b1, 14'h0000, 1'b1}};

  daoc_top #(.SLEEP_CYC(20)) daoc_top_inst (
    .I_CLOCK(clk), .I_RST_B(rst_b), .I_WB_CYC(cyc), .I_WB_STB(stb),
    .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(4'h1), .I_WB_DAT(wdat),
    .O_WB_DAT(rdat), .O_WB_ACK(ack), .O_IRQ(irq), .I_MODE_LEVEL(lvl),
    .I_POWER_DOWN_REQUEST_CHAN_A(pd_a), .I_POWER_DOWN_REQUEST_CHAN_B(pd_b),
    .I_OUTPUT_ENABLE_N_CHAN_A(oe_a), .I_OUTPUT_ENABLE_N_CHAN_B(oe_b),
    .I_BUS_SWAP_SELECT(swap), .I_SAMPLE_CLOCK_CHAN_A(sclk),
    .I_SAMPLE_CLOCK_CHAN_B(sclk), .I_CONV_A(conv_a), .I_CONV_B(conv_b),
    .O_OUTPUT_BUS_A(bus_a), .O_OUTPUT_BUS_A_OE(output_enable_n_chan_a),
    .O_OUTPUT_BUS_B(bus_b), .O_OUTPUT_BUS_B_OE(output_enable_n_chan_b),
    .O_OVERRANGE_FLAG_BUS_A(overrange_flag_bus_a), .O_OVERRANGE_FLAG_BUS_A_OE(ofoea),
    .O_OVERRANGE_FLAG_BUS_B(overrange_flag_bus_b), .O_OVERRANGE_FLAG_BUS_B_OE(ofoeb),
    .O_DATA_VALID_BUS_A(va), .O_DATA_VALID_BUS_B(vb),
    .O_TWOS_FORMAT(twos), .O_STABILISER_ON(dcs),
    .O_REF_POWER_CHAN_A(rfa), .O_REF_POWER_CHAN_B(rfb));

  daoc_rx daoc_rx_inst (.i_clk(clk), .i_mux(bus_swap_select), .i_swap(swap_cmd),
    .i_valid(va), .i_bus(bus_a), .o_sclk(sclk), .o_swap(swap),
    .o_word(word));

  // ***************************************************************
  // helper tasks
  // ***************************************************************
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    // only the watchdog ends a wait that never sees ack
    do
    begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wait_va(input int lim);
    int n;
    n = 0;
    while (va !== 1'b1 && n < lim)
    begin
      @(posedge clk);
      n++;
    end
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ***************************************************************
  // clock, watchdog and sequence
  // ***************************************************************
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial
  begin
    #1000000;
    miscompares++;
    final_report;
  end

  initial
  begin
    {rst_b, cyc, stb, we, adr, wdat, lvl, bus_swap_select} = '0;
    {pd_a, pd_b, oe_a, oe_b, swap_cmd} = 5'h1f;
    conv_a = '0;
    conv_b = '0;
    tick(10);
    rst_b <= 1'b1;
    tick(2);
    wb(1'b0, 8'h0c, 32'h0);
    chk("mask reset", 32'h0, q);
    wb(1'b0, 8'h40, 32'h0);
    chk("unmapped read", 32'h0, q);
    {pd_a, pd_b, oe_a, oe_b} <= 4'h0;
    wait_va(500);
    chk("valid a b", 32'h3, {vb, va});
    $display("test wake done");
    foreach (rows[i])
    begin
      lvl <= rows[i].lvl;
      conv_a <= {rows[i].code, rows[i].pos, rows[i].neg};
      conv_b <= {rows[i].code, rows[i].pos, rows[i].neg};
      tick(40);
      chk("bus a", rows[i].exp, bus_a);
      chk("bus b", rows[i].exp, bus_b);
      chk("flag a", rows[i].of, overrange_flag_bus_a);
      chk("flag b", rows[i].of, overrange_flag_bus_b);
      chk("rx word", rows[i].exp, word);
      chk("twos", rows[i].lvl[1], twos);
      chk("stabiliser", ^rows[i].lvl, dcs);
    end
    $display("test rows done");
    wb(1'b1, 8'h00, 32'h5);
    tick(4);
    chk("override", 32'h3, {twos, dcs});
    wb(1'b1, 8'h00, 32'h0);
    lvl <= 2'h0;
    conv_a <= {14'h1234, 2'h0};
    conv_b <= {14'h0abc, 2'h0};
    tick(40);
    chk("straight", {14'h1234, 14'h0abc}, {bus_a, bus_b});
    swap_cmd <= 1'b0;
    tick(10);
    chk("swapped", {14'h0abc, 14'h1234}, {bus_a, bus_b});
    bus_swap_select <= 1'b1;
    oe_b <= 1'b1;
    tick(40);
    chk("mux word", 32'h0abc, word);
    chk("mux bus b off", 32'h0, output_enable_n_chan_b);
    bus_swap_select <= 1'b0;
    oe_b <= 1'b0;
    swap_cmd <= 1'b1;
    oe_a <= 1'b1;
    tick(10);
    chk("enables", 32'h3, {output_enable_n_chan_a, ofoea, output_enable_n_chan_b, ofoeb});
    oe_a <= 1'b0;
    pd_a <= 1'b1;
    tick(10);
    chk("nap pins", 32'h3, {output_enable_n_chan_a, rfa, output_enable_n_chan_b});
    wb(1'b0, 8'h04, 32'h0);
    chk("nap state", 32'h12, q[7:0]);
    pd_a <= 1'b0;
    tick(400);
    chk("nap recovery", 32'h0, va);
    wait_va(1500);
    chk("nap back", 32'h1, va);
    $display("test nap done");
    {oe_a, pd_a} <= 2'h3;
    tick(10);
    chk("sleep pins", 32'h1, {rfa, output_enable_n_chan_a, rfb});
    {oe_a, pd_a} <= 2'h0;
    tick(10);
    chk("sleep recovery", 32'h0, va);
    wait_va(100);
    chk("sleep back", 32'h1, va);
    $display("test sleep done");
    wb(1'b1, 8'h08, 32'hf);
    wb(1'b1, 8'h0c, 32'h1);
    chk("irq idle", 32'h0, irq);
    conv_a <= 16'h0002;
    tick(40);
    chk("irq set", 32'h1, irq);
    wb(1'b0, 8'h08, 32'h0);
    chk("irq status", 32'h1, q[0]);
    conv_a <= '0;
    wb(1'b1, 8'h08, 32'h1);
    tick(2);
    chk("irq clear", 32'h0, irq);
    $display("test irq done");
    rst_b <= 1'b0;
    tick(2);
    chk("reset outputs", 32'h0, {ack, irq, output_enable_n_chan_a, output_enable_n_chan_b, rfa, rfb, va});
    rst_b <= 1'b1;
    tick(2);
    wb(1'b0, 8'h0c, 32'h0);
    chk("mask after reset", 32'h0, q);
    $display("test reset done");
    final_report;
  end
endmodule
`default_nettype wire
